// *** src/ibs_pkg.sv ***
package ibs_pkg;

    // ------------------------------------------------------------
    // widths and counter values
    // ------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
    localparam logic [CNT_W-1:0] CNT_THREE = 4'h3;

    localparam int TALLY_W = 2;
    localparam logic [TALLY_W-1:0] TALLY_ZERO = 2'h0;
    localparam logic [TALLY_W-1:0] TALLY_MAX = 2'h3;

    localparam int RETRY_W = 4;
    localparam logic [RETRY_W-1:0] RETRY_ZERO = 4'h0;
    localparam logic [RETRY_W-1:0] RETRY_ONE = 4'h1;
    // transactions in a row with no data moved before giving up
    localparam logic [RETRY_W-1:0] RETRY_LIMIT = 4'h8;

    // ------------------------------------------------------------
    // extended status bits 39:32, seen here as 7:0
    // ------------------------------------------------------------
    localparam int STAT_W = 8;
    localparam int STAT_MASTER_ABORT = 7;
    localparam int STAT_TARGET_ABORT = 6;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ,
        ST_WRITE,
        ST_READ,
        ST_DEAD,
        ST_EVAL
    } ibs_state_e;

endpackage : ibs_pkg

// *** src/ibs_edge_detect.sv ***
`timescale 1ns/100ps
module ibs_edge_detect (
    input wire logic clk,
    input wire logic nrst,
    input wire logic data_phase,
    output logic data_phase_delayed,
    output logic data_phase_end_pulse
);

    logic dly_q;
    logic dly_d;

    always_comb
    begin
        dly_d = data_phase;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dly_q <= 1'b0;
        else
            dly_q <= dly_d;
    end

    assign data_phase_delayed = dly_q;
    assign data_phase_end_pulse = !data_phase && dly_q;

endmodule : ibs_edge_detect

// *** src/ibs_backup_tally.sv ***
`timescale 1ns/100ps
module ibs_backup_tally (
    input wire logic clk,
    input wire logic nrst,
    input wire logic anticipated,
    input wire logic actual,
    input wire logic back_up,
    output logic [ibs_pkg::TALLY_W-1:0] tally
);

    // saturating up/down: one increment, two decrements
    logic [ibs_pkg::TALLY_W-1:0] tally_q;
    logic [ibs_pkg::TALLY_W-1:0] tally_d;
    logic [ibs_pkg::TALLY_W:0] up;
    logic [ibs_pkg::TALLY_W:0] down;

    always_comb
    begin
        up = {1'b0, tally_q} + {2'h0, anticipated};
        down = {2'h0, actual} + {2'h0, back_up};
        if (up <= down)
            tally_d = ibs_pkg::TALLY_ZERO;
        else if (up - down > {1'b0, ibs_pkg::TALLY_MAX})
            tally_d = ibs_pkg::TALLY_MAX;
        else
            tally_d = 2'(up - down);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tally_q <= ibs_pkg::TALLY_ZERO;
        else
            tally_q <= tally_d;
    end

    assign tally = tally_q;

endmodule : ibs_backup_tally

// *** src/ibs_sequencer.sv ***
// Contract
// - a started transaction completes at least one data phase.
// - data phase is registered each clock; fell = now low, was high.
// - abort flag clears in address phase, loads bits 39 or 38 in data phase.
// - status bits valid one clock late; keep final data phase status.
// - 4-bit counter: reset zero, load on start, decrement on valid data.
// - counter counts real transfers only; never adjusted by FIFO back-up.
// - idle does nothing; start moves to request, else stay idle.
// - request lasts one cycle, then write if dir high, else read.
// - stay in transfer state until the data phase fell pulse.
// - transaction ends by retry, disconnect, timer or user completion.
// - on fell: abort set goes to fatal state, else to evaluation.
// - fatal state holds; a clear input returns it to idle.
// - evaluation waits while backing up, then idle if done, fatal state on give-up, else request.
// - retries are not flagged; requests repeat until counter reaches zero or retries give up.
// - count retries and abandon after too many in a row.
// - meant for total bursts shorter than the FIFO capacity.
// - reset forces idle; unused encodings go to idle next clock.
// - back-up high only in evaluation with tally nonzero; steps tally down.
// - request pulse is high exactly one cycle, in the request state.
`timescale 1ns/100ps
module ibs_sequencer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic dir,
    input wire logic [ibs_pkg::CNT_W-1:0] burst_length,
    input wire logic addr_phase_n,
    input wire logic data_phase,
    input wire logic transfer_valid,
    input wire logic src_en,
    input wire logic fifo_empty,
    input wire logic [ibs_pkg::STAT_W-1:0] ext_status_bits,
    input wire logic dead_clear,
    output logic request,
    output logic complete,
    output logic back_up,
    output logic done,
    output logic fatal,
    output logic dead,
    output logic retry_abandon,
    output logic busy,
    output logic data_phase_end_pulse,
    output logic [ibs_pkg::CNT_W-1:0] remaining_count,
    output logic [ibs_pkg::RETRY_W-1:0] retry_count
);

    // ------------------------------------------------------------
    // edge detect and back-up tally
    // ------------------------------------------------------------
    logic data_phase_delayed;
    logic [ibs_pkg::TALLY_W-1:0] tally;
    logic anticipated;

    ibs_edge_detect u_edge (
        .clk(clk),
        .nrst(nrst),
        .data_phase(data_phase),
        .data_phase_delayed(data_phase_delayed),
        .data_phase_end_pulse(data_phase_end_pulse)
    );

    // an empty FIFO cannot advance, so it cannot over-advance
    assign anticipated = src_en && !fifo_empty;

    ibs_backup_tally u_tally (
        .clk(clk),
        .nrst(nrst),
        .anticipated(anticipated),
        .actual(transfer_valid),
        .back_up(back_up),
        .tally(tally)
    );

    // ------------------------------------------------------------
    // abort status capture
    // ------------------------------------------------------------
    logic fatal_q;
    logic fatal_d;

    // status arrives a clock late, so the last data phase wins
    always_comb
    begin
        fatal_d = fatal_q;
        if (!addr_phase_n)
            fatal_d = 1'b0;
        else if (data_phase)
            fatal_d = ext_status_bits[ibs_pkg::STAT_MASTER_ABORT]
                | ext_status_bits[ibs_pkg::STAT_TARGET_ABORT];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fatal_q <= 1'b0;
        else
            fatal_q <= fatal_d;
    end

    assign fatal = fatal_q;

    // ------------------------------------------------------------
    // transfer counter
    // ------------------------------------------------------------
    logic [ibs_pkg::CNT_W-1:0] cnt_q;
    logic [ibs_pkg::CNT_W-1:0] cnt_d;

    // no back-up input here: only completed phases are counted
    always_comb
    begin
        cnt_d = cnt_q;
        if (start)
            cnt_d = burst_length;
        else if (transfer_valid)
            cnt_d = cnt_q - ibs_pkg::CNT_ONE;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= ibs_pkg::CNT_ZERO;
        else
            cnt_q <= cnt_d;
    end

    assign remaining_count = cnt_q;
    assign done = (cnt_q == ibs_pkg::CNT_ZERO);

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    ibs_pkg::ibs_state_e state_q;
    ibs_pkg::ibs_state_e state_d;
    logic moved_q;
    logic moved_d;
    logic [ibs_pkg::RETRY_W-1:0] retry_q;
    logic [ibs_pkg::RETRY_W-1:0] retry_d;
    logic abandon_q;
    logic abandon_d;
    logic give_up;

    // a transaction that moved no data is taken as a retry
    assign give_up = !moved_q
        && (retry_q + ibs_pkg::RETRY_ONE >= ibs_pkg::RETRY_LIMIT);

    always_comb
    begin
        state_d = state_q;
        moved_d = moved_q;
        retry_d = retry_q;
        abandon_d = abandon_q;
        case (state_q)
            ibs_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    state_d = ibs_pkg::ST_REQ;
                    retry_d = ibs_pkg::RETRY_ZERO;
                    abandon_d = 1'b0;
                end
            end
            ibs_pkg::ST_REQ:
            begin
                moved_d = 1'b0;
                if (dir)
                    state_d = ibs_pkg::ST_WRITE;
                else
                    state_d = ibs_pkg::ST_READ;
            end
            ibs_pkg::ST_WRITE, ibs_pkg::ST_READ:
            begin
                if (transfer_valid)
                    moved_d = 1'b1;
                // the core guarantees one data phase, so fell always comes
                if (data_phase_end_pulse)
                begin
                    if (fatal_q)
                        state_d = ibs_pkg::ST_DEAD;
                    else
                        state_d = ibs_pkg::ST_EVAL;
                end
            end
            ibs_pkg::ST_DEAD:
            begin
                if (dead_clear)
                    state_d = ibs_pkg::ST_IDLE;
            end
            ibs_pkg::ST_EVAL:
            begin
                if (!back_up)
                begin
                    if (done)
                        state_d = ibs_pkg::ST_IDLE;
                    else if (give_up)
                    begin
                        state_d = ibs_pkg::ST_DEAD;
                        abandon_d = 1'b1;
                    end
                    else
                        state_d = ibs_pkg::ST_REQ;
                    if (moved_q)
                        retry_d = ibs_pkg::RETRY_ZERO;
                    else
                        retry_d = retry_q + ibs_pkg::RETRY_ONE;
                end
            end
            default:
                state_d = ibs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ibs_pkg::ST_IDLE;
            moved_q <= 1'b0;
            retry_q <= ibs_pkg::RETRY_ZERO;
            abandon_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            moved_q <= moved_d;
            retry_q <= retry_d;
            abandon_q <= abandon_d;
        end
    end

    assign request = (state_q == ibs_pkg::ST_REQ);
    assign back_up = (state_q == ibs_pkg::ST_EVAL)
        && (tally != ibs_pkg::TALLY_ZERO);
    assign dead = (state_q == ibs_pkg::ST_DEAD);
    assign busy = (state_q != ibs_pkg::ST_IDLE);
    assign retry_abandon = abandon_q;
    assign retry_count = retry_q;

    // ------------------------------------------------------------
    // completion request
    // ------------------------------------------------------------
    logic hold_q;
    logic hold_d;
    logic assert_complete;

    // pipelined counter compare, no wait states; fifo level flags unused, bursts must fit
    assign assert_complete = (cnt_q == ibs_pkg::CNT_ONE && request)
        || (cnt_q == ibs_pkg::CNT_TWO && data_phase_delayed)
        || (cnt_q == ibs_pkg::CNT_THREE && transfer_valid);

    always_comb
    begin
        hold_d = hold_q;
        if (data_phase_end_pulse)
            hold_d = 1'b0;
        else if (assert_complete)
            hold_d = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hold_q <= 1'b0;
        else
            hold_q <= hold_d;
    end

    assign complete = assert_complete || hold_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    req_one_cycle_a:
    assert property (request |=> !request && $past(state_q) == ibs_pkg::ST_REQ)
    else $error("request pulse longer than one cycle");

    req_branch_a:
    assert property (request |=> state_q == (dir ? ibs_pkg::ST_WRITE : ibs_pkg::ST_READ))
    else $error("wrong branch after request");

    fell_detect_a:
    assert property (data_phase_end_pulse == (!data_phase && $past(data_phase) && $past(nrst)))
    else $error("data phase fell pulse wrong");

    abort_clear_a:
    assert property (!addr_phase_n |=> !fatal)
    else $error("abort flag not cleared in address phase");

    abort_load_a:
    assert property (addr_phase_n && data_phase |=>
        fatal == $past(ext_status_bits[7] | ext_status_bits[6]))
    else $error("abort flag not loaded in data phase");

    count_load_a:
    assert property (start |=> remaining_count == $past(burst_length))
    else $error("counter did not load burst length");

    count_step_a:
    assert property (!start && !transfer_valid |=> $stable(remaining_count))
    else $error("counter moved without a transfer");

    idle_wait_a:
    assert property (state_q == ibs_pkg::ST_IDLE && !start |=> state_q == ibs_pkg::ST_IDLE)
    else $error("left idle without start");

    xfer_exit_a:
    assert property ((state_q == ibs_pkg::ST_WRITE || state_q == ibs_pkg::ST_READ)
        && data_phase_end_pulse |=>
        state_q == ($past(fatal) ? ibs_pkg::ST_DEAD : ibs_pkg::ST_EVAL))
    else $error("wrong exit from transfer state");

    xfer_stay_a:
    assert property ((state_q == ibs_pkg::ST_WRITE || state_q == ibs_pkg::ST_READ)
        && !data_phase_end_pulse |=> $stable(state_q))
    else $error("left transfer state early");
    dead_hold_a:
    assert property (dead && !dead_clear |=> dead)
    else $error("fatal state not held");

    backup_step_a:
    assert property (back_up && !anticipated && !transfer_valid |=>
        tally == $past(tally) - 2'h1)
    else $error("back-up did not step tally down");

    eval_done_a:
    assert property (state_q == ibs_pkg::ST_EVAL && !back_up && done |=>
        state_q == ibs_pkg::ST_IDLE)
    else $error("evaluation did not return to idle");
    cov_write_backup: cover property (state_q == ibs_pkg::ST_WRITE ##[1:64] back_up);
    cov_read_done: cover property (state_q == ibs_pkg::ST_READ ##[1:64]
        state_q == ibs_pkg::ST_IDLE);
    cov_fatal: cover property (data_phase_end_pulse && fatal ##1 dead);
    cov_abandon: cover property ($rose(retry_abandon));
endmodule : ibs_sequencer

// *** verif/ibs_core_model.sv ***
`timescale 1ns/100ps
module ibs_core_model (
    input wire logic clk,
    input wire logic request,
    output logic addr_phase_n,
    output logic data_phase,
    output logic transfer_valid,
    output logic src_en,
    output logic [7:0] ext_status_bits
);
    int nv_q[$];
    int ex_q[$];
    logic [1:0] ab_q[$];
    int nv;
    int ex;
    int n;
    logic [1:0] ab;
    logic req_seen = 1'b0;

    task automatic push(input int v, input int e, input logic [1:0] a);
        nv_q.push_back(v);
        ex_q.push_back(e);
        ab_q.push_back(a);
    endtask : push

    always @(posedge clk) req_seen <= request;

    initial
    begin
        addr_phase_n = 1'b1;
        data_phase = 1'b0;
        transfer_valid = 1'b0;
        src_en = 1'b0;
        ext_status_bits = 8'h5A;
        forever
        begin
            @(negedge clk);
            // released status lines: pattern changes every cycle
            ext_status_bits = ~ext_status_bits;
            if (req_seen === 1'b1)
            begin
                nv = (nv_q.size() > 0) ? nv_q.pop_front() : 1;
                ex = (ex_q.size() > 0) ? ex_q.pop_front() : 0;
                ab = (ab_q.size() > 0) ? ab_q.pop_front() : 2'h0;
                n = (nv + ex > 0) ? nv + ex : 1;
                addr_phase_n = 1'b0;
                @(negedge clk);
                addr_phase_n = 1'b1;
                for (int i = 0; i < n; i++)
                begin
                    data_phase = 1'b1;
                    transfer_valid = (i < nv);
                    // extra cycles model speculative source advances
                    src_en = (i < nv + ex);
                    // abort code shown at the last data phase
                    ext_status_bits = {(i == n - 1) ? ab : 2'h0, 6'h15};
                    @(negedge clk);
                end
                data_phase = 1'b0;
                transfer_valid = 1'b0;
                src_en = 1'b0;
                ext_status_bits = ~ext_status_bits;
            end
        end
    end
endmodule : ibs_core_model

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic dir = 1'b0;
    logic [3:0] burst_length = 4'h0;
    logic fifo_empty = 1'b0;
    logic dead_clear = 1'b0;
    logic addr_phase_n, data_phase, transfer_valid, src_en;
    logic [7:0] ext_status_bits;
    logic request, complete, back_up, done, fatal, dead, retry_abandon, busy, data_phase_end_pulse;
    logic [3:0] remaining_count, retry_count;
    logic [15:0] expq[$];
    logic [3:0] nreq = 4'h0;
    logic [3:0] nbu = 4'h0;
    logic pbusy = 1'b0;
    logic pdead = 1'b0;
    logic pdp = 1'b0;
    logic cseen = 1'b0;
    logic [31:0] rnd = 32'h53667E81;
    int n_errors = 0;
    int checks_done = 0;

    initial forever #25 clk = ~clk;

    ibs_sequencer dut (.clk(clk), .nrst(nrst), .start(start), .dir(dir),
        .burst_length(burst_length), .addr_phase_n(addr_phase_n),
        .data_phase(data_phase), .transfer_valid(transfer_valid), .src_en(src_en),
        .fifo_empty(fifo_empty), .ext_status_bits(ext_status_bits),
        .dead_clear(dead_clear), .request(request), .complete(complete),
        .back_up(back_up), .done(done), .fatal(fatal), .dead(dead),
        .retry_abandon(retry_abandon), .busy(busy), .data_phase_end_pulse(data_phase_end_pulse),
        .remaining_count(remaining_count), .retry_count(retry_count));

    ibs_core_model m (.clk(clk), .request(request), .addr_phase_n(addr_phase_n),
        .data_phase(data_phase), .transfer_valid(transfer_valid), .src_en(src_en),
        .ext_status_bits(ext_status_bits));

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr_next

    // requests, back-up cycles, dead, abandon, abort flag, complete seen, final count
    function automatic logic [15:0] pack(input int r, input int b, input logic d,
        input logic a, input logic f, input logic cs, input int c);
        return {r[3:0], b[3:0], d, a, f, cs, c[3:0]};
    endfunction : pack

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic burst(input string nm, input logic [3:0] len, input logic wr,
        input logic [15:0] exp);
        int t;
        t = 0;
        @(negedge clk);
        burst_length = len;
        dir = wr;
        start = 1'b1;
        expq.push_back(exp);
        @(negedge clk);
        start = 1'b0;
        while (busy !== 1'b0 && dead !== 1'b1 && t < 400)
        begin
            @(negedge clk);
            t++;
        end
        if (t >= 400)
            check("burst hang", 16'h1, 16'h0);
        @(negedge clk);
        $display("test %s done", nm);
    endtask : burst

    task automatic clear_dead;
        repeat (6) @(negedge clk);
        check("dead hold", {15'h0, dead}, 16'h1);
        dead_clear = 1'b1;
        @(negedge clk);
        dead_clear = 1'b0;
        check("dead exit", {15'h0, busy}, 16'h0);
    endtask : clear_dead

    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (nrst !== 1'b1)
        begin
            nreq = 4'h0;
            nbu = 4'h0;
            pbusy = 1'b0;
            pdead = 1'b0;
            pdp = 1'b0;
            cseen = 1'b0;
        end
        else
        begin
            check("fell", {15'h0, data_phase_end_pulse}, {15'h0, !data_phase && pdp});
            if ((pbusy === 1'b1 && busy === 1'b0 && pdead === 1'b0) ||
                (dead === 1'b1 && pdead === 1'b0))
            begin
                if (expq.size() > 0)
                    check("burst", {nreq, nbu, dead, retry_abandon, fatal, cseen, remaining_count},
                        expq.pop_front());
                else
                    check("unexpected end", 16'h1, 16'h0);
                nreq = 4'h0;
                nbu = 4'h0;
                cseen = 1'b0;
            end
            nreq = nreq + {3'h0, request};
            nbu = nbu + {3'h0, back_up};
            cseen = cseen | complete;
            pbusy = busy;
            pdead = dead;
            pdp = data_phase;
        end
    end

    initial
    begin
        #(50 * 20000);
        n_errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        logic [1:0] ex;
        logic cmp_exp;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        m.push(2, 0, 2'h0);
        burst("write", 4'h2, 1'b1, pack(1, 0, 0, 0, 0, 0, 0));
        m.push(1, 2, 2'h0);
        m.push(2, 0, 2'h0);
        burst("disconnect", 4'h3, 1'b0, pack(2, 2, 0, 0, 0, 1, 0));
        m.push(0, 0, 2'h0);
        m.push(0, 0, 2'h0);
        m.push(1, 0, 2'h0);
        burst("retry", 4'h1, 1'b1, pack(3, 0, 0, 0, 0, 1, 0));
        for (int k = 1; k < 3; k++)
        begin
            m.push(1, 0, k[1:0]);
            burst("abort", 4'h2, 1'b1, pack(1, 0, 1, 0, 1, 0, 1));
            clear_dead();
        end
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr_next(rnd);
            ex = {1'b0, rnd[5]} + {1'b0, rnd[6]};
            // an empty FIFO only ever meets a read request
            fifo_empty = ~rnd[3] & rnd[4];
            // length two: data and valid arrive together, the compare never hits
            cmp_exp = (rnd[1:0] != 2'h1);
            m.push(int'({2'h0, rnd[1:0]}) + 1, int'(ex), 2'h0);
            burst("random", {2'h0, rnd[1:0]} + 4'h1, rnd[3],
                pack(1, fifo_empty ? 0 : int'(ex), 0, 0, 0, cmp_exp, 0));
        end
        fifo_empty = 1'b0;
        repeat (8) m.push(0, 0, 2'h0);
        burst("abandon", 4'h2, 1'b1, pack(8, 0, 1, 1, 0, 1, 2));
        check("retry count", {12'h0, retry_count}, 16'(ibs_pkg::RETRY_LIMIT));
        clear_dead();
        m.push(3, 0, 2'h0);
        @(negedge clk);
        burst_length = 4'h3;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b0;
        #5;
        check("reset", {10'h0, busy, done, remaining_count}, 16'h0010);
        @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        $display("test reset done");
        m.push(1, 0, 2'h0);
        burst("after reset", 4'h1, 1'b1, pack(1, 0, 0, 0, 0, 1, 0));
        check("pending", 16'(expq.size()), 16'h0);
        final_report();
    end
endmodule : tb_top
